// ==== design/vbc_bank_ctrl.sv ====
// start/stop command and running status for the first voice bank
`timescale 1ns/1ps

// Summary of operation
// - 64 channels, two banks; this is 0-31
// - bank channels are playback only, own modulators
// - start register read returns running status
// - stopped channel halts engines, adds nothing
// - stop write of one halts channel
// - loop off and offset at or past end stops
// - envelope at floor stops channel
// - delay-stop countdown at zero stops channel
// - only a start write sets running
// - start write of one starts channel
// - zero bits written change nothing
// - stop register reads same status
module vbc_bank_ctrl
  import vbc_pkg::*;
(
  // clock and reset
  input  wire logic                     clk,
  input  wire logic                     reset_n,

  // host i/o port
  input  wire vbc_io_req_t              io_req,
  output      logic [DATA_W-1:0]        io_rdata,
  output      logic                     io_rvalid,

  // stop condition report from address and envelope engines
  input  wire vbc_chan_report_t         chan_report,

  // engine control
  output      logic [BANK_CHANNELS-1:0] chan_running,
  output      logic [BANK_CHANNELS-1:0] chan_start,
  output      logic [BANK_CHANNELS-1:0] chan_stop,

  // hardware stop event, for flags kept elsewhere
  output      vbc_stop_evt_t            hw_stop_evt,

  // sample fetch request gate
  input  wire vbc_fetch_t               fetch_in,
  output      vbc_fetch_t               fetch_out,

  // mixer contribution gate
  input  wire vbc_mix_t                 mix_in,
  output      vbc_mix_t                 mix_out
);

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [BANK_CHANNELS-1:0] running;
    logic [BANK_CHANNELS-1:0] start_p;
    logic [BANK_CHANNELS-1:0] stop_p;
    logic [DATA_W-1:0]        rdata;
    logic                     rvalid;
    vbc_stop_evt_t            evt;
    vbc_fetch_t               fetch;
    vbc_mix_t                 mix;
  } vbc_ctrl_state_t;

  vbc_ctrl_state_t s_r;
  vbc_ctrl_state_t s_nxt;

  // ----------------------------------------------------------------------
  // hardware stop detection
  // ----------------------------------------------------------------------
  vbc_stop_evt_t stop_evt;

  vbc_stop_detect u_stop_detect (
    .clk      (clk),
    .reset_n  (reset_n),
    .report   (chan_report),
    .stop_evt (stop_evt)
  );

  // ----------------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------------
  logic hit_start;
  logic hit_stop;
  logic start_wr;
  logic stop_wr;
  logic status_rd;

  assign hit_start = (io_req.addr == START_OFFSET);
  assign hit_stop  = (io_req.addr == STOP_OFFSET);
  assign start_wr  = io_req.wr && hit_start;
  assign stop_wr   = io_req.wr && hit_stop;
  assign status_rd = io_req.rd && (hit_start || hit_stop);

  // ----------------------------------------------------------------------
  // per-channel command masks
  // ----------------------------------------------------------------------
  logic [BANK_CHANNELS-1:0] start_mask;
  logic [BANK_CHANNELS-1:0] stop_mask;
  logic [BANK_CHANNELS-1:0] hw_mask;
  logic [BANK_CHANNELS-1:0] clear_mask;

  genvar ch;
  generate
    for (ch = 0; ch < BANK_CHANNELS; ch = ch + 1) begin : g_chan
      // zero bits leave the channel alone
      assign start_mask[ch] = start_wr && io_req.wdata[ch];
      assign stop_mask[ch]  = stop_wr && io_req.wdata[ch];
      assign hw_mask[ch]    = stop_evt.valid &&
                              (stop_evt.chan == CHAN_W'(ch));
      // a start in the same cycle overrides a hardware stop
      assign clear_mask[ch] = (stop_mask[ch] || hw_mask[ch]) &&
                              !start_mask[ch];
    end
  endgenerate

  // ----------------------------------------------------------------------
  // running status and engine commands
  // ----------------------------------------------------------------------
  always_comb begin
    s_nxt = s_r;

    // only a start write raises a bit; stops only lower it
    s_nxt.running = (s_r.running & ~clear_mask) | start_mask;
    s_nxt.start_p = start_mask;
    s_nxt.stop_p  = clear_mask;

    // forward the hardware stop only when it took effect
    s_nxt.evt       = stop_evt;
    s_nxt.evt.valid = stop_evt.valid &&
                      !start_mask[stop_evt.chan];

    // both registers read back the running status
    s_nxt.rvalid = io_req.rd;
    if (status_rd) begin
      s_nxt.rdata = s_r.running;
    end else if (io_req.rd) begin
      s_nxt.rdata = UNMAPPED_VAL;
    end

    // stopped channels do not fetch and pass a muted sample to the mixer
    s_nxt.fetch.chan  = fetch_in.chan;
    s_nxt.fetch.valid = fetch_in.valid &&
                        s_r.running[fetch_in.chan];
    s_nxt.mix.chan    = mix_in.chan;
    s_nxt.mix.valid   = mix_in.valid;
    if (mix_in.valid && s_r.running[mix_in.chan]) begin
      s_nxt.mix.sample = mix_in.sample;
    end else begin
      s_nxt.mix.sample = SAMPLE_MUTE;
    end
  end

  // ----------------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      s_r         <= '0;
      s_r.running <= STATUS_RESET;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------
  // engines run address, fetch, interpolation and envelope on this level
  assign chan_running = s_r.running;
  assign chan_start   = s_r.start_p;
  assign chan_stop    = s_r.stop_p;
  assign io_rdata     = s_r.rdata;
  assign io_rvalid    = s_r.rvalid;
  assign hw_stop_evt  = s_r.evt;
  assign fetch_out    = s_r.fetch;
  assign mix_out      = s_r.mix;

endmodule

// ==== common/vbc_pkg.sv ====
// shared constants and carrier types of the voice bank start/stop control
package vbc_pkg;

  // ----------------------------------------------------------------------
  // channel organisation
  // ----------------------------------------------------------------------
  localparam int TOTAL_CHANNELS = 64;
  localparam int BANK_CHANNELS  = 32;
  localparam int CHAN_W         = 5;
  localparam int DATA_W         = 32;

  // ----------------------------------------------------------------------
  // i/o port register map (byte addresses)
  // ----------------------------------------------------------------------
  localparam int               IO_ADDR_W    = 8;
  localparam logic [7:0]       START_OFFSET = 8'h80;
  localparam logic [7:0]       STOP_OFFSET  = 8'h84;
  localparam logic [31:0]      STATUS_RESET = 32'h0000_0000;
  localparam logic [31:0]      UNMAPPED_VAL = 32'h0000_0000;

  // ----------------------------------------------------------------------
  // engine report fields
  // ----------------------------------------------------------------------
  localparam int               OFFSET_W     = 16;
  localparam int               ENV_W        = 12;
  localparam int               DLY_W        = 16;
  localparam int               SAMPLE_W     = 16;
  // attenuation in 1/64 dB steps: 4095 steps is -63.984375 dB
  localparam logic [11:0]      ENV_FLOOR    = 12'hFFF;
  localparam logic [15:0]      DLY_DONE     = 16'h0000;
  localparam logic [15:0]      SAMPLE_MUTE  = 16'h0000;

  // ----------------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic                 wr;
    logic                 rd;
    logic [IO_ADDR_W-1:0] addr;
    logic [DATA_W-1:0]    wdata;
  } vbc_io_req_t;

  typedef struct packed {
    logic                valid;
    logic [CHAN_W-1:0]   chan;
    logic                loop_enable;
    logic [OFFSET_W-1:0] current_sample_offset;
    logic [OFFSET_W-1:0] end_sample_offset;
    logic [ENV_W-1:0]    current_envelope_level;
    logic                delay_stop_mode;
    logic [DLY_W-1:0]    envelope_delay_count;
  } vbc_chan_report_t;

  typedef struct packed {
    logic              valid;
    logic [CHAN_W-1:0] chan;
    logic              out_of_data;
    logic              env_floor;
    logic              delay_expired;
  } vbc_stop_evt_t;

  typedef struct packed {
    logic              valid;
    logic [CHAN_W-1:0] chan;
  } vbc_fetch_t;

  typedef struct packed {
    logic                valid;
    logic [CHAN_W-1:0]   chan;
    logic [SAMPLE_W-1:0] sample;
  } vbc_mix_t;

endpackage

// ==== design/vbc_stop_detect.sv ====
// per-channel hardware stop condition detector
`timescale 1ns/1ps

module vbc_stop_detect
  import vbc_pkg::*;
(
  // clock and reset
  input  wire logic             clk,
  input  wire logic             reset_n,
  // channel report from address and envelope engines
  input  wire vbc_chan_report_t report,
  // registered stop event
  output      vbc_stop_evt_t    stop_evt
);

  vbc_stop_evt_t s_r;
  vbc_stop_evt_t s_nxt;

  // ----------------------------------------------------------------------
  // condition decode
  // ----------------------------------------------------------------------
  always_comb begin
    s_nxt               = '0;
    s_nxt.chan          = report.chan;
    s_nxt.out_of_data   = report.valid && !report.loop_enable &&
                          (report.current_sample_offset >=
                           report.end_sample_offset);
    s_nxt.env_floor     = report.valid &&
                          (report.current_envelope_level ==
                           ENV_FLOOR);
    s_nxt.delay_expired = report.valid && report.delay_stop_mode &&
                          (report.envelope_delay_count ==
                           DLY_DONE);
    s_nxt.valid         = s_nxt.out_of_data || s_nxt.env_floor ||
                          s_nxt.delay_expired;
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign stop_evt = s_r;

endmodule

// ==== verification/vbc_bank_sva.sv ====
// assertion checker for the voice bank start/stop control
`timescale 1ns/1ps
module vbc_bank_sva
  import vbc_pkg::*;
(
  // clock and reset
  input wire logic                     clk,
  input wire logic                     reset_n,
  // watched ports
  input wire vbc_io_req_t              io_req,
  input wire logic [DATA_W-1:0]        io_rdata,
  input wire logic                     io_rvalid,
  input wire vbc_chan_report_t         chan_report,
  input wire logic [BANK_CHANNELS-1:0] chan_running,
  input wire logic [BANK_CHANNELS-1:0] chan_start,
  input wire logic [BANK_CHANNELS-1:0] chan_stop,
  input wire vbc_stop_evt_t            hw_stop_evt,
  input wire vbc_fetch_t               fetch_in,
  input wire vbc_fetch_t               fetch_out,
  input wire vbc_mix_t                 mix_in,
  input wire vbc_mix_t                 mix_out
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  wire st_wr = io_req.wr && io_req.addr == START_OFFSET;
  wire sp_wr = io_req.wr && io_req.addr == STOP_OFFSET;
  wire [CHAN_W-1:0] rc = chan_report.chan;
  sequence s_empty;
    chan_report.valid && !chan_report.loop_enable &&
      chan_report.current_sample_offset >= chan_report.end_sample_offset;
  endsequence
  sequence s_floor;
    chan_report.valid && chan_report.current_envelope_level == ENV_FLOOR;
  endsequence
  sequence s_dly;
    chan_report.valid && chan_report.delay_stop_mode &&
      chan_report.envelope_delay_count == DLY_DONE;
  endsequence
  a_start_sets: assert property (st_wr |=>
    (chan_running & $past(io_req.wdata)) == $past(io_req.wdata))
    else $error("start write did not set status");
  a_stop_clears: assert property (sp_wr |=>
    (chan_running & $past(io_req.wdata)) == 0)
    else $error("stop write did not clear status");
  a_start_pulse: assert property (st_wr |=>
    chan_start == $past(io_req.wdata))
    else $error("start pulse does not match written mask");
  a_stop_pulse: assert property (sp_wr |=>
    (chan_stop & $past(io_req.wdata)) == $past(io_req.wdata))
    else $error("stop pulse missing for written mask");
  a_rise_cause: assert property ((chan_running & ~$past(chan_running)) != 0 |->
    $past(st_wr) && (chan_running & ~$past(chan_running | io_req.wdata)) == 0)
    else $error("status rose without start write");
  a_read_status: assert property (io_req.rd &&
    (io_req.addr == START_OFFSET || io_req.addr == STOP_OFFSET) |=>
    io_rvalid && io_rdata == $past(chan_running))
    else $error("status read wrong");
  a_empty_stops: assert property (s_empty ##1 !st_wr |=>
    !chan_running[$past(rc, 2)] && hw_stop_evt.valid && hw_stop_evt.out_of_data)
    else $error("out of data did not stop");
  a_floor_stops: assert property (s_floor ##1 !st_wr |=>
    !chan_running[$past(rc, 2)] && hw_stop_evt.valid && hw_stop_evt.env_floor)
    else $error("envelope floor did not stop");
  a_delay_stops: assert property (s_dly ##1 !st_wr |=>
    !chan_running[$past(rc, 2)] && hw_stop_evt.delay_expired)
    else $error("delay expiry did not stop");
  a_start_wins: assert property (s_floor ##1 st_wr && io_req.wdata[$past(rc)]
    |=> chan_running[$past(rc, 2)])
    else $error("hardware stop beat start");
  a_fetch_gate: assert property (1'b1 |=> fetch_out.valid ==
    $past(fetch_in.valid && chan_running[fetch_in.chan]))
    else $error("fetch passed for stopped channel");
  a_mix_gate: assert property (1'b1 |=> mix_out.sample ==
    $past((mix_in.valid && chan_running[mix_in.chan]) ? mix_in.sample :
      SAMPLE_MUTE))
    else $error("stopped channel reached mix");
endmodule

bind vbc_bank_ctrl vbc_bank_sva i_sva (.clk, .reset_n, .io_req, .io_rdata,
  .io_rvalid, .chan_report, .chan_running, .chan_start, .chan_stop,
  .hw_stop_evt, .fetch_in,
  .fetch_out, .mix_in, .mix_out);

// ==== verification/vbc_host_model.sv ====
// host software model driving the i/o port
`timescale 1ns/1ps
module vbc_host_model
  import vbc_pkg::*;
(
  // clock
  input  wire logic              clk,
  // i/o port
  output      vbc_io_req_t       io_req,
  input  wire logic [DATA_W-1:0] io_rdata,
  input  wire logic              io_rvalid
);
  initial io_req = '0;
  // one access; starts just after an edge, ends one idle edge later
  task automatic access(input logic w, input logic [7:0] a,
                        input logic [31:0] d, output logic [31:0] q,
                        output logic v);
    io_req = '{wr: w, rd: !w, addr: a, wdata: d};
    @(posedge clk);
    #1;
    q = io_rdata;
    v = io_rvalid;
    // released fields carry inverted values, not the last ones
    io_req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
    // an idle edge keeps a following call from re-driving in this step
    @(posedge clk);
    #1;
  endtask
endmodule

// ==== verification/testbench.sv ====
// self-checking testbench of the voice bank start/stop control
`timescale 1ns/1ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin fails++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, a, b); end end
module testbench
  import vbc_pkg::*;
;
  logic                     clk = 1'b0;
  logic                     reset_n = 1'b0;
  vbc_io_req_t              io_req;
  logic [DATA_W-1:0]        io_rdata, q;
  logic                     io_rvalid, v;
  vbc_chan_report_t         rpt = '0;
  logic [BANK_CHANNELS-1:0] run, stp, sta;
  vbc_stop_evt_t            hse;
  vbc_fetch_t               f_in = '0, f_out;
  vbc_mix_t                 m_in = '0, m_out;
  int                       fails = 0, num_checks = 0, cycles = 0;

  vbc_host_model i_host (.clk(clk), .io_req(io_req), .io_rdata(io_rdata),
    .io_rvalid(io_rvalid));
  vbc_bank_ctrl i_dut (.clk(clk), .reset_n(reset_n), .io_req(io_req),
    .io_rdata(io_rdata), .io_rvalid(io_rvalid), .chan_report(rpt),
    .chan_running(run), .chan_start(sta), .chan_stop(stp), .hw_stop_evt(hse),
    .fetch_in(f_in), .fetch_out(f_out), .mix_in(m_in), .mix_out(m_out));

  initial forever #4 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 2000) begin
      fails++;
      give_verdict();
    end
  end

  task automatic give_verdict;
    if (fails == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    i_host.access(1'b1, a, d, q, v);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    i_host.access(1'b0, a, 32'h0000_0000, q, v);
    `CHK({v, q}, {1'b1, e})
  endtask
  // kind: 0 out of data, 1 floor, 2 delay expiry, 3 no stop cause
  task automatic send_rpt(input int ch, input int kind);
    rpt = '{valid: 1'b1, chan: ch[4:0], loop_enable: kind != 0,
      current_sample_offset: 16'h1234, end_sample_offset: 16'h1234,
      current_envelope_level: (kind == 1) ? ENV_FLOOR : 12'hFFE,
      delay_stop_mode: 1'b1,
      envelope_delay_count: (kind == 2) ? DLY_DONE : 16'h0001};
    @(posedge clk);
    #1;
    rpt = ~rpt;
  endtask
  task automatic hw_stop(input int ch, input int kind, input logic e);
    send_rpt(ch, kind);
    @(posedge clk);
    #1;
    `CHK({run[ch], stp[ch]}, {e, !e})
    `CHK(hse, {!e, ch[4:0], kind == 0, kind == 1, kind == 2})
  endtask
  task automatic start_wins;
    wr(START_OFFSET, 32'h0000_0010);
    send_rpt(4, 1);
    fork
      wr(START_OFFSET, 32'h0000_0010);
      begin
        @(posedge clk);
        #1;
        `CHK({run[4], stp[4], hse.valid}, 3'b100)
      end
    join
    @(posedge clk);
    #1;
    `CHK(run[4], 1'b1)
  endtask
  task automatic gate(input int ch, input logic e);
    f_in = '{valid: 1'b1, chan: ch[4:0]};
    m_in = '{valid: 1'b1, chan: ch[4:0], sample: 16'hA5A5};
    @(posedge clk);
    #1;
    `CHK({f_out, m_out}, {e, ch[4:0], 1'b1, ch[4:0], e ? 16'hA5A5 : 16'h0000})
  endtask

  initial begin
    repeat (8) @(posedge clk);
    #1;
    reset_n = 1'b1;
    @(posedge clk);
    #1;
    `CHK(run, STATUS_RESET)
    fork
      wr(START_OFFSET, 32'h8000_0005);
      begin
        @(posedge clk);
        #1;
        `CHK(sta, 32'h8000_0005)
      end
    join
    `CHK(run, 32'h8000_0005)
    rd_chk(START_OFFSET, 32'h8000_0005);
    rd_chk(STOP_OFFSET, 32'h8000_0005);
    rd_chk(8'h88, UNMAPPED_VAL);
    wr(START_OFFSET, 32'h0000_0000);
    wr(STOP_OFFSET, 32'h0000_0000);
    `CHK(run, 32'h8000_0005)
    wr(STOP_OFFSET, 32'h0000_0001);
    `CHK(run, 32'h8000_0004)
    wr(8'h88, 32'hFFFF_FFFF);
    `CHK(run, 32'h8000_0004)
    wr(START_OFFSET, 32'h0000_000F);
    hw_stop(0, 0, 1'b0);
    hw_stop(1, 1, 1'b0);
    hw_stop(2, 2, 1'b0);
    hw_stop(3, 3, 1'b1);
    start_wins();
    gate(4, 1'b1);
    gate(0, 1'b0);
    give_verdict();
  end
endmodule
